// *** pkg/cts_pkg.sv ***
/*
  Package for the cascade trigger synchroniser: register map, field
  positions, reset values, encodings and timing constants.
  Assumes a 100 MHz pclk and an APB master with 32-bit data.
*/
package cts_pkg;

  // register byte offsets
  localparam logic [11:0] CTS_CASC_OFS = 12'h000;
  localparam logic [11:0] CTS_DLY_OFS = 12'h004;
  localparam logic [11:0] CTS_PIN_OFS = 12'h008;
  localparam logic [11:0] CTS_STAT_OFS = 12'h00C;

  // cascade control fields
  localparam int CTS_EN_BIT = 0;
  localparam int CTS_ROLE_BIT = 1;
  localparam int CTS_CYC_LSB = 16;
  // pin config fields
  localparam int CTS_DIR_BIT = 24;
  localparam int CTS_POL_BIT = 16;
  localparam int CTS_IFN_LSB = 8;
  localparam int CTS_OFN_LSB = 0;
  // status fields
  localparam int CTS_ST_DRV_BIT = 0;
  localparam int CTS_ST_WAIT_BIT = 1;
  localparam int CTS_ST_PIN_BIT = 2;
  localparam int CTS_CNT_LSB = 8;

  // encodings
  localparam logic CTS_ROLE_MASTER = 1'b1;
  localparam logic CTS_ROLE_SLAVE = 1'b0;
  localparam logic CTS_DIR_IN = 1'b1;
  localparam logic CTS_DIR_OUT = 1'b0;
  localparam logic CTS_POL_LIGHT = 1'b0;
  localparam logic [7:0] CTS_IFN_TRIG = 8'h01;
  localparam logic [7:0] CTS_OFN_TRIG = 8'h03;

  // reset values
  localparam logic [15:0] CTS_CYC_RST = 16'h0000;
  localparam logic [31:0] CTS_DLY_RST = 32'h0000_0000;
  localparam logic CTS_DIR_RST = 1'b1;
  localparam logic CTS_EN_RST = 1'b0;
  localparam logic [7:0] CTS_FN_RST = 8'h00;

  // timing
  localparam int CTS_CLK_MHZ = 100;
  localparam int CTS_US_NS = 1000;
  localparam int CTS_CLK_NS = 10;
  localparam int CTS_US_CYC = CTS_US_NS / CTS_CLK_NS;
  localparam int CTS_MS_US = 1000;
  localparam int CTS_PULSE_US = 10;
  localparam int CTS_PULSE_CYC = CTS_PULSE_US * CTS_US_CYC;

  typedef enum logic [1:0] {
    CTS_IDLE = 2'b00,
    CTS_WAIT = 2'b01,
    CTS_SCAN = 2'b10
  } cts_state_e;

endpackage

// *** rtl/cts_us_tick.sv ***
/*
  Microsecond tick generator: one-cycle pulse every microsecond of pclk.
  Assumes pclk at the rate set in the package.
*/
`timescale 1ns/1ps
`default_nettype none
module cts_us_tick
  import cts_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // tick
  output logic tick
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;

  always_comb begin
    if (cnt == 8'(CTS_US_CYC - 1)) begin
      next_cnt = 8'h00;
    end else begin
      next_cnt = cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign tick = (cnt == 8'(CTS_US_CYC - 1));

endmodule
`default_nettype wire

// *** rtl/cts_cascade_sync.sv ***
/*
  Cascade trigger synchroniser: APB register file, master trigger
  generator and slave trigger-to-scan delay on the multipurpose pin.
  Assumes a single 100 MHz pclk; the pin arrives asynchronously and the
  scan engine takes scan_start as a one-cycle request.
*/
`timescale 1ns/1ps
`default_nettype none
module cts_cascade_sync
  import cts_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // multipurpose pin
  input wire logic mp_pin_in,
  output logic mp_pin_out,
  output logic mp_pin_oe,
  // scan engine
  output logic scan_start
);

  // registers
  logic casc_en, role;
  logic [15:0] cyc_ms;
  logic [31:0] dly_us;
  logic dir, pol;
  logic [7:0] ifn, ofn;
  logic next_casc_en, next_role, next_dir, next_pol;
  logic [15:0] next_cyc_ms;
  logic [31:0] next_dly_us;
  logic [7:0] next_ifn, next_ofn;
  logic [31:0] next_prdata;
  logic [7:0] trig_cnt, next_trig_cnt;

  logic wr_en, rd_en, addr_ok;

  function automatic logic ofs_hit(input logic [11:0] a);
    return a == CTS_CASC_OFS || a == CTS_DLY_OFS ||
           a == CTS_PIN_OFS || a == CTS_STAT_OFS;
  endfunction

  assign addr_ok = ofs_hit(paddr);
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // mode decode
  logic is_master, is_slave, trig_out_sel, trig_in_sel;
  assign is_master = casc_en && role == CTS_ROLE_MASTER;
  assign is_slave = casc_en && role == CTS_ROLE_SLAVE;
  assign trig_out_sel = is_master && dir == CTS_DIR_OUT &&
                        ofn == CTS_OFN_TRIG;
  assign trig_in_sel = is_slave && dir == CTS_DIR_IN &&
                       ifn == CTS_IFN_TRIG;

  // pin input: three flops, change when stages two and three agree
  logic [2:0] pin_sync;
  logic pin_level, next_pin_level;
  logic pin_active, pin_active_d, trig_edge;

  always_comb begin
    next_pin_level = pin_level;
    if (pin_sync[1] == pin_sync[2]) begin
      next_pin_level = pin_sync[2];
    end
  end

  // light switching: trigger asserted when pin high, else inverted
  assign pin_active = (pol == CTS_POL_LIGHT) ? pin_level : !pin_level;
  assign trig_edge = pin_active && !pin_active_d;

  // master period generator
  logic [9:0] us_in_ms, next_us_in_ms;
  logic [15:0] ms_cnt, next_ms_cnt;
  logic us_tick, master_fire;
  logic [9:0] pulse_cnt, next_pulse_cnt;
  logic trig_drive;

  cts_us_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(us_tick)
  );

  always_comb begin
    next_us_in_ms = us_in_ms;
    next_ms_cnt = ms_cnt;
    master_fire = 1'b0;
    if (!is_master || cyc_ms == 16'h0000) begin
      next_us_in_ms = 10'h000;
      next_ms_cnt = 16'h0000;
    end else if (us_tick) begin
      if (us_in_ms == 10'(CTS_MS_US - 1)) begin
        next_us_in_ms = 10'h000;
        if (ms_cnt >= cyc_ms - 16'h0001) begin
          next_ms_cnt = 16'h0000;
          master_fire = 1'b1;
        end else begin
          next_ms_cnt = ms_cnt + 16'h0001;
        end
      end else begin
        next_us_in_ms = us_in_ms + 10'h001;
      end
    end
  end

  always_comb begin
    next_pulse_cnt = pulse_cnt;
    if (!trig_out_sel) begin
      next_pulse_cnt = 10'h000;
    end else if (master_fire) begin
      next_pulse_cnt = 10'(CTS_PULSE_CYC);
    end else if (pulse_cnt != 10'h000) begin
      next_pulse_cnt = pulse_cnt - 10'h001;
    end
  end

  assign trig_drive = pulse_cnt != 10'h000;

  // slave delay state machine
  cts_state_e state, next_state;
  logic [31:0] dly_cnt, next_dly_cnt;

  always_comb begin
    next_state = state;
    next_dly_cnt = dly_cnt;
    if (!trig_in_sel) begin
      next_state = CTS_IDLE;
      next_dly_cnt = 32'h0;
    end else begin
      unique case (state)
        CTS_IDLE: begin
          if (trig_edge) begin
            next_dly_cnt = 32'h0;
            next_state = (dly_us == 32'h0) ? CTS_SCAN : CTS_WAIT;
          end
        end
        CTS_WAIT: begin
          if (us_tick) begin
            if (dly_cnt >= dly_us - 32'h1) begin
              next_state = CTS_SCAN;
            end else begin
              next_dly_cnt = dly_cnt + 32'h1;
            end
          end
        end
        CTS_SCAN: begin
          next_state = CTS_IDLE;
        end
        default: begin
          next_state = CTS_IDLE;
        end
      endcase
    end
  end

  // register writes and reads
  always_comb begin
    next_casc_en = casc_en;
    next_role = role;
    next_cyc_ms = cyc_ms;
    next_dly_us = dly_us;
    next_dir = dir;
    next_pol = pol;
    next_ifn = ifn;
    next_ofn = ofn;
    next_prdata = prdata;
    next_trig_cnt = trig_cnt;
    if (state == CTS_SCAN) begin
      next_trig_cnt = trig_cnt + 8'h01;
    end
    if (wr_en) begin
      unique case (paddr)
        CTS_CASC_OFS: begin
          next_casc_en = pwdata[CTS_EN_BIT];
          next_role = pwdata[CTS_ROLE_BIT];
          next_cyc_ms = pwdata[CTS_CYC_LSB +: 16];
        end
        CTS_DLY_OFS: begin
          next_dly_us = pwdata;
        end
        CTS_PIN_OFS: begin
          next_dir = pwdata[CTS_DIR_BIT];
          next_pol = pwdata[CTS_POL_BIT];
          next_ifn = pwdata[CTS_IFN_LSB +: 8];
          next_ofn = pwdata[CTS_OFN_LSB +: 8];
        end
        default: begin
          next_trig_cnt = 8'h00;
        end
      endcase
    end
    if (rd_en) begin
      next_prdata = 32'h0;
      unique case (paddr)
        CTS_CASC_OFS: begin
          next_prdata[CTS_EN_BIT] = casc_en;
          next_prdata[CTS_ROLE_BIT] = role;
          next_prdata[CTS_CYC_LSB +: 16] = cyc_ms;
        end
        CTS_DLY_OFS: next_prdata = dly_us;
        CTS_PIN_OFS: begin
          next_prdata[CTS_DIR_BIT] = dir;
          next_prdata[CTS_POL_BIT] = pol;
          next_prdata[CTS_IFN_LSB +: 8] = ifn;
          next_prdata[CTS_OFN_LSB +: 8] = ofn;
        end
        CTS_STAT_OFS: begin
          next_prdata[CTS_ST_DRV_BIT] = trig_drive;
          next_prdata[CTS_ST_WAIT_BIT] = state == CTS_WAIT;
          next_prdata[CTS_ST_PIN_BIT] = pin_active;
          next_prdata[CTS_CNT_LSB +: 8] = trig_cnt;
        end
        default: next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      casc_en <= CTS_EN_RST;
      role <= CTS_ROLE_SLAVE;
      cyc_ms <= CTS_CYC_RST;
      dly_us <= CTS_DLY_RST;
      dir <= CTS_DIR_RST;
      pol <= CTS_POL_LIGHT;
      ifn <= CTS_FN_RST;
      ofn <= CTS_FN_RST;
      prdata <= 32'h0;
      trig_cnt <= 8'h00;
      pin_sync <= 3'b000;
      pin_level <= 1'b0;
      pin_active_d <= 1'b0;
      us_in_ms <= 10'h000;
      ms_cnt <= 16'h0000;
      pulse_cnt <= 10'h000;
      state <= CTS_IDLE;
      dly_cnt <= 32'h0;
      scan_start <= 1'b0;
      mp_pin_out <= 1'b0;
      mp_pin_oe <= 1'b0;
    end else begin
      casc_en <= next_casc_en;
      role <= next_role;
      cyc_ms <= next_cyc_ms;
      dly_us <= next_dly_us;
      dir <= next_dir;
      pol <= next_pol;
      ifn <= next_ifn;
      ofn <= next_ofn;
      prdata <= next_prdata;
      trig_cnt <= next_trig_cnt;
      pin_sync <= {pin_sync[1:0], mp_pin_in};
      pin_level <= next_pin_level;
      pin_active_d <= pin_active;
      us_in_ms <= next_us_in_ms;
      ms_cnt <= next_ms_cnt;
      pulse_cnt <= next_pulse_cnt;
      state <= next_state;
      dly_cnt <= next_dly_cnt;
      scan_start <= next_state == CTS_SCAN;
      // output driven only for master, output direction and trigger function; polarity maps active to level
      mp_pin_oe <= trig_out_sel;
      mp_pin_out <= trig_out_sel &&
                    (trig_drive ^ (pol != CTS_POL_LIGHT));
    end
  end

  // assertions
  default clocking cts_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_trig_taken;
    trig_in_sel && state == CTS_IDLE && trig_edge;
  endsequence

  // scan_start is registered from next_state, so it shares the scan cycle
  sequence s_scan_pulse;
    (state == CTS_SCAN && scan_start) ##1 !scan_start;
  endsequence

  chk_slave_no_pace: assert property (!is_master |=>
    pulse_cnt == 10'h000 && !mp_pin_oe)
    else $error("slave drives trigger");

  chk_master_fires: assert property (master_fire && trig_out_sel |=>
    trig_drive && mp_pin_oe)
    else $error("master trigger not generated");

  chk_en_needed: assert property (!casc_en |=>
    !scan_start && !mp_pin_oe)
    else $error("activity with cascade off");

  chk_pin_dir: assert property (mp_pin_oe |->
    dir == CTS_DIR_OUT || $past(dir) == CTS_DIR_OUT)
    else $error("pin driven while input");

  chk_out_func: assert property ($rose(trig_drive) |->
    $past(ofn) == CTS_OFN_TRIG)
    else $error("trigger out without trigger function");

  chk_pulse_len: assert property ($rose(trig_drive) &&
    trig_out_sel |-> trig_drive [*8])
    else $error("trigger pulse too short");

  chk_zero_delay: assert property (s_trig_taken ##0
    (dly_us == 32'h0) |=> s_scan_pulse)
    else $error("zero delay scan missed");

  chk_one_scan: assert property (scan_start |=> !scan_start)
    else $error("more than one scan per trigger");

  chk_scan_cause: assert property ($rose(scan_start) |->
    $past(state) != CTS_IDLE || $past(trig_edge))
    else $error("scan without trigger");

  chk_light_pol: assert property (pol == CTS_POL_LIGHT &&
    trig_out_sel |=> mp_pin_out == $past(trig_drive))
    else $error("light switching polarity wrong");

endmodule
`default_nettype wire

// *** tb/cts_peer_model.sv ***
/*
  Peer unit model: an upstream cascade master that drives one trigger
  pulse per request. Assumes fire is a one-cycle request on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module cts_peer_model #(
  parameter int PULSE_CYC = 232
) (
  // clock and request
  input wire logic pclk,
  input wire logic fire,
  // pin drive
  output logic trig_out,
  output logic trig_oe
);
  int cnt = 0;

  // master enabled and paced only on request
  always @(posedge pclk) begin
    if (fire) begin
      cnt <= PULSE_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // active-high pulse, line released after it
  assign trig_out = (cnt > 0);
  assign trig_oe = (cnt > 0);
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
/*
  Self-checking bench for the cascade trigger synchroniser.
  Assumes the pin line has a pull-down and a 100 MHz pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench import cts_pkg::*;;
  localparam int FIRST_US = 3;
  localparam int SECOND_US = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, mp_pin_out, mp_pin_oe, scan_start;
  logic fire = 1'b0;
  logic peer_out, peer_oe, pin_line;
  logic [31:0] rd;
  logic rerr;
  int err_total = 0;
  int cmp_count = 0;
  int scans = 0;

  always #5 pclk = ~pclk;
  // released line sits low through its pull-down
  assign pin_line = mp_pin_oe ? mp_pin_out : (peer_oe ? peer_out : 1'b0);
  always @(posedge pclk) begin
    if (scan_start === 1'b1) begin
      scans <= scans + 1;
    end
  end

  cts_cascade_sync cts_cascade_sync_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mp_pin_in(pin_line), .mp_pin_out(mp_pin_out), .mp_pin_oe(mp_pin_oe),
    .scan_start(scan_start));
  cts_peer_model cts_peer_model_inst (.pclk(pclk), .fire(fire),
    .trig_out(peer_out), .trig_oe(peer_oe));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s: %h not %h", $time, msg, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic bound(input int t, input int lim);
    if (t >= lim) begin
      check(32'(t), 32'(lim - 1), "wait ran out");
      conclude();
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    bound(n, 50);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic t_reset();
    apb(1'b0, CTS_CASC_OFS, 32'h0);
    check(rd, 32'h0000_0000, "cascade reset");
    apb(1'b0, CTS_DLY_OFS, 32'h0);
    check(rd, CTS_DLY_RST, "delay reset");
    apb(1'b0, CTS_PIN_OFS, 32'h0);
    check(rd, 32'h0100_0000, "pin reset");
    check(32'(mp_pin_oe), 32'h0, "oe at reset");
    check(32'(pready), 32'h1, "ready");
    apb(1'b0, 12'h010, 32'h0);
    check({rd[30:0], rerr}, 32'h1, "unmapped read");
    $display("test reset done");
  endtask

  // trigger from the peer, then time the delayed scan
  task automatic t_slave(input int d);
    int t, n0, lo;
    n0 = scans;
    t = 0;
    lo = (d > 1) ? (d - 1) * CTS_US_CYC : 0;
    apb(1'b1, CTS_DLY_OFS, 32'(d));
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    while (scans == n0 && t < 2000) begin
      @(posedge pclk);
      t++;
      fire <= (t == 300 && d > 4);
    end
    bound(t, 2000);
    check(32'(t >= lo && t <= d * CTS_US_CYC + 120), 32'h1, "delay");
    repeat (300) @(posedge pclk);
    check(32'(scans - n0), 32'h1, "one scan");
    $display("test slave delay %0d us done", d);
  endtask

  task automatic t_none(input logic [31:0] casc, input logic [31:0] pin);
    int n0;
    n0 = scans;
    apb(1'b1, CTS_PIN_OFS, pin);
    apb(1'b1, CTS_CASC_OFS, casc);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (600) @(posedge pclk);
    check(32'(scans - n0), 32'h0, "no scan");
    check(32'(mp_pin_oe), 32'h0, "pin not driven");
    $display("test inactive slave done");
  endtask

  task automatic t_master();
    int t;
    apb(1'b1, CTS_PIN_OFS, 32'h0000_0003);
    apb(1'b1, CTS_CASC_OFS, 32'h0001_0003);
    // oe is registered one edge after the write lands
    @(posedge pclk);
    check(32'(mp_pin_oe), 32'h1, "master drives");
    t = 0;
    while (mp_pin_out !== 1'b1 && t < 100200) begin
      @(posedge pclk);
      t++;
    end
    bound(t, 100200);
    check(32'(t > (CTS_MS_US - 2) * CTS_US_CYC), 32'h1, "period");
    t = 0;
    while (mp_pin_out === 1'b1 && t < 1000) begin
      @(posedge pclk);
      t++;
    end
    check(32'(t), 32'(CTS_PULSE_CYC), "pulse width");
    apb(1'b1, CTS_CASC_OFS, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    check(32'(mp_pin_oe), 32'h0, "disabled master");
    $display("test master done");
  endtask

  task automatic t_idle();
    apb(1'b1, CTS_PIN_OFS, 32'h0100_0100);
    apb(1'b1, CTS_CASC_OFS, 32'h0000_0001);
    repeat (500) @(posedge pclk);
    check(32'(scans), 32'h0, "no self pacing");
    check(32'(mp_pin_oe), 32'h0, "slave input");
    $display("test idle slave done");
  endtask

  task automatic t_count();
    apb(1'b0, CTS_STAT_OFS, 32'h0);
    check(32'(rd[CTS_CNT_LSB +: 8]), 32'h3, "scan count");
    apb(1'b1, CTS_STAT_OFS, 32'h0);
    apb(1'b0, CTS_STAT_OFS, 32'h0);
    check(32'(rd[CTS_CNT_LSB +: 8]), 32'h0, "count cleared");
    $display("test scan count done");
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_idle();
    t_slave(0);
    t_slave(FIRST_US);
    t_slave(FIRST_US + SECOND_US);
    t_count();
    t_none(32'h0000_0000, 32'h0100_0100);
    t_none(32'h0000_0001, 32'h0100_0000);
    t_master();
    conclude();
  end
endmodule
`default_nettype wire
